// file: core/tc_remote_pkg.sv
package tc_remote_pkg;

	// ------------------------------------------------------------
	// Clock and line timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned DIV_2400      = CLK_HZ / 2400;
	localparam int unsigned DIV_4800      = CLK_HZ / 4800;
	localparam int unsigned DIV_9600      = CLK_HZ / 9600;
	localparam int unsigned DIV_19200     = CLK_HZ / 19200;
	localparam int unsigned DIV_38400     = CLK_HZ / 38400;
	localparam int unsigned DIV_57600     = CLK_HZ / 57600;
	localparam int unsigned DIV_115200    = CLK_HZ / 115200;
	localparam int unsigned MS_TIME_MS    = 1;
	localparam int unsigned MS_CYCLES_DEF = CLK_HZ / 1000 * MS_TIME_MS;
	localparam int          MS_CNT_W      = 17;

	localparam logic [2:0] BAUD_2400   = 3'h0;
	localparam logic [2:0] BAUD_4800   = 3'h1;
	localparam logic [2:0] BAUD_9600   = 3'h2;
	localparam logic [2:0] BAUD_19200  = 3'h3;
	localparam logic [2:0] BAUD_38400  = 3'h4;
	localparam logic [2:0] BAUD_57600  = 3'h5;
	localparam logic [1:0] PAR_NONE    = 2'h0;
	localparam logic [1:0] PAR_ODD     = 2'h2;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_LINE       = 8'h00;
	localparam logic [7:0] REG_TMO        = 8'h04;
	localparam logic [7:0] REG_STAT       = 8'h08;
	localparam int         LINE_W         = 7;
	localparam int         LINE_BAUD_LSB  = 0;
	localparam int         LINE_EIGHT_BIT = 3;
	localparam int         LINE_PAR_LSB   = 4;
	localparam int         LINE_STOP2_BIT = 6;
	localparam logic [6:0] LINE_RST       = 7'h0c;
	localparam int         TMO_W          = 9;
	localparam int         TMO_EN_BIT     = 8;
	localparam logic [8:0] TMO_RST        = 9'h10a;
	localparam logic       PERSIST_RST    = 1'b1;

	// ------------------------------------------------------------
	// Frame layout and codes
	// ------------------------------------------------------------
	localparam int         FRAME_MAX   = 18;
	localparam int         TX_MAX      = 11;
	localparam logic [4:0] FRAME_OVH   = 5'h03;
	localparam logic [3:0] GRP_SYS     = 4'h0;
	localparam logic [3:0] GRP_SET     = 4'h4;
	localparam logic [3:0] GRP_REQ     = 4'h6;
	localparam logic [7:0] CMD_DEVTYPE = 8'h11;
	localparam logic [7:0] CMD_PERSIST = 8'h9c;
	localparam logic [7:0] CMD_GEN     = 8'h86;
	localparam logic [7:0] CMD_MUTE    = 8'h87;
	localparam logic [7:0] CMD_PTIME   = 8'h04;
	localparam logic [7:0] CMD_PUSER   = 8'h05;
	localparam logic [7:0] CMD_TIMER   = 8'h36;
	localparam logic [7:0] CMD_GENREQ  = 8'h0a;
	localparam logic [7:0] CMD_RDR     = 8'h0c;
	localparam logic [7:0] CMD_STAT    = 8'h20;
	localparam logic [7:0] GEN_START   = 8'h00;
	localparam logic [7:0] GEN_STOP    = 8'h01;
	localparam logic [7:0] GEN_LOAD    = 8'h02;
	localparam logic [7:0] SEL_TIME    = 8'h01;
	localparam logic [7:0] SEL_USER    = 8'h10;
	localparam logic [7:0] SEL_BOTH    = 8'h11;
	localparam logic [7:0] ACK_W1      = 8'h10;
	localparam logic [7:0] ACK_W2      = 8'h01;
	localparam logic [7:0] NAK_W1      = 8'h11;
	localparam logic [7:0] NAK_W2      = 8'h12;
	localparam logic [7:0] DEVTYPE_W1  = 8'h12;
	localparam logic [7:0] RET_ONE     = 8'h71;
	localparam logic [7:0] RET_FOUR    = 8'h74;
	localparam logic [7:0] RET_EIGHT   = 8'h78;
	localparam logic [7:0] CODE_GEN_T  = 8'h08;
	localparam logic [7:0] CODE_GEN_U  = 8'h09;
	localparam logic [7:0] CODE_LTC_T  = 8'h04;
	localparam logic [7:0] CODE_LTC_U  = 8'h05;
	localparam logic [7:0] CODE_VITC_T = 8'h06;
	localparam logic [7:0] CODE_VITC_U = 8'h07;
	localparam logic [7:0] ERR_FRAME   = 8'h40;
	localparam logic [7:0] ERR_OVR     = 8'h20;
	localparam logic [7:0] ERR_PAR     = 8'h10;
	localparam logic [7:0] ERR_SUM     = 8'h04;
	localparam logic [7:0] ERR_DATA    = 8'h02;
	localparam logic [7:0] ERR_CMD     = 8'h01;
	localparam int         CAP_LTC_RD  = 3;
	localparam int         CAP_VITC_RD = 0;

endpackage

// file: core/char_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface char_link_if;
	logic [2:0] baud_sel;
	logic       eight;
	logic [1:0] par_mode;
	logic       two_stop;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_ferr;
	logic       rx_perr;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       tx_busy;

	modport engine (input baud_sel, eight, par_mode, two_stop, tx_valid, tx_data,
		output rx_valid, rx_data, rx_ferr, rx_perr, tx_busy);
	modport user (output baud_sel, eight, par_mode, two_stop, tx_valid, tx_data,
		input rx_valid, rx_data, rx_ferr, rx_perr, tx_busy);
endinterface

`default_nettype wire

// file: core/serial_char_engine.sv
`timescale 1ns/10ps
`default_nettype none

module serial_char_engine
	import tc_remote_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   sys_rst,
	input  wire logic   rxd,
	output var  logic   txd_q,
	char_link_if.engine lk
);

	function automatic logic [15:0] bit_div(input logic [2:0] s);
		case (s)
			BAUD_2400:  return 16'(DIV_2400);
			BAUD_4800:  return 16'(DIV_4800);
			BAUD_9600:  return 16'(DIV_9600);
			BAUD_19200: return 16'(DIV_19200);
			BAUD_38400: return 16'(DIV_38400);
			BAUD_57600: return 16'(DIV_57600);
			default:    return 16'(DIV_115200);
		endcase
	endfunction

	function automatic logic par_of(input logic [7:0] w, input logic odd);
		return (^w) ^ odd;
	endfunction

	// ------------------------------------------------------------
	// Shared framing
	// ------------------------------------------------------------
	wire logic [15:0] div   = bit_div(lk.baud_sel);
	wire logic [3:0]  nd    = lk.eight ? 4'd8 : 4'd7;
	wire logic        pe    = lk.par_mode != PAR_NONE;
	wire logic        odd   = lk.par_mode == PAR_ODD;
	wire logic [3:0]  nbits = nd + {3'd0, pe} + (lk.two_stop ? 4'd2 : 4'd1);

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	logic [11:0] tx_sr_q;
	logic [3:0]  tx_cnt_q;
	logic [15:0] tx_div_q;
	logic [11:0] tx_fr;
	wire logic [7:0] tx_word = lk.eight ? lk.tx_data : {1'b0, lk.tx_data[6:0]};

	always_comb
	begin
		tx_fr = '1;
		tx_fr[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			if (i < int'(nd))
				tx_fr[i + 1] = tx_word[i];
		if (pe)
			tx_fr[nd + 4'd1] = par_of(tx_word, odd);
	end

	assign lk.tx_busy = tx_cnt_q != 4'd0;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_sr_q  <= '1;
			tx_cnt_q <= 4'd0;
			tx_div_q <= 16'h0000;
			txd_q    <= 1'b1;
		end
		else
		begin
			txd_q <= tx_sr_q[0];
			if (lk.tx_valid && !lk.tx_busy)
			begin
				tx_sr_q  <= tx_fr;
				tx_cnt_q <= nbits + 4'd1;
				tx_div_q <= div - 16'd1;
			end
			else if (lk.tx_busy && tx_div_q == 16'h0000)
			begin
				tx_sr_q  <= {1'b1, tx_sr_q[11:1]};
				tx_cnt_q <= tx_cnt_q - 4'd1;
				tx_div_q <= div - 16'd1;
			end
			else if (lk.tx_busy)
				tx_div_q <= tx_div_q - 16'd1;
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	logic        rx_m_q;
	logic        rx_s_q;
	logic [10:0] rx_sr_q;
	logic [3:0]  rx_cnt_q;
	logic [15:0] rx_div_q;
	logic        rx_done_q;
	wire logic [10:0] al = rx_sr_q >> (4'd11 - nbits);
	wire logic [7:0]  rx_word = lk.eight ? al[7:0] : {1'b0, al[6:0]};
	wire logic [3:0]  stop_at = nd + {3'd0, pe};
	wire logic        stop_bad = !al[stop_at] || (lk.two_stop && !al[stop_at + 4'd1]);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_m_q   <= 1'b1;
			rx_s_q   <= 1'b1;
			rx_cnt_q <= 4'd0;
			rx_div_q <= 16'h0000;
			rx_sr_q  <= '0;
		end
		else
		begin
			rx_m_q <= rxd;
			rx_s_q <= rx_m_q;
			if (rx_cnt_q == 4'd0 && !rx_s_q)
			begin
				rx_cnt_q <= nbits + 4'd1;
				rx_div_q <= {1'b0, div[15:1]};
			end
			else if (rx_cnt_q != 4'd0 && rx_div_q != 16'h0000)
				rx_div_q <= rx_div_q - 16'd1;
			else if (rx_cnt_q != 4'd0)
			begin
				rx_div_q <= div - 16'd1;
				// A start bit gone high by mid-bit was a glitch
				if (rx_cnt_q == nbits + 4'd1 && rx_s_q)
					rx_cnt_q <= 4'd0;
				else
					rx_cnt_q <= rx_cnt_q - 4'd1;
				if (rx_cnt_q != nbits + 4'd1)
					rx_sr_q <= {rx_s_q, rx_sr_q[10:1]};
			end
		end
	end

	wire logic rx_done_d = rx_cnt_q == 4'd1 && rx_div_q == 16'h0000;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_done_q   <= 1'b0;
			lk.rx_valid <= 1'b0;
			lk.rx_data  <= 8'h00;
			lk.rx_ferr  <= 1'b0;
			lk.rx_perr  <= 1'b0;
		end
		else
		begin
			rx_done_q   <= rx_done_d;
			lk.rx_valid <= rx_done_q;
			if (rx_done_q)
			begin
				lk.rx_data <= rx_word;
				lk.rx_ferr <= stop_bad;
				lk.rx_perr <= pe && (al[nd] != par_of(rx_word, odd));
			end
		end
	end

endmodule

`default_nettype wire

// file: core/tc_remote_ctl.sv
`timescale 1ns/10ps
`default_nettype none

module tc_remote_ctl
	import tc_remote_pkg::*;
#(
	parameter int unsigned MS_CYCLES  = MS_CYCLES_DEF,
	parameter logic [2:0]  DEV_TYPE   = 3'h2, // Arbitrary value
	parameter logic [7:0]  FW_VERSION = 8'h10 // Arbitrary value
)(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        rxd,
	output var  logic        txd_q,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output var  logic [31:0] rd_data_q,
	input  wire logic [4:0]  capability,
	input  wire logic [31:0] gen_time,
	input  wire logic [31:0] gen_user,
	input  wire logic [31:0] ltc_time,
	input  wire logic [31:0] ltc_user,
	input  wire logic [31:0] vitc_time,
	input  wire logic [31:0] vitc_user,
	input  wire logic [31:0] rdr_time,
	input  wire logic [31:0] rdr_user,
	input  wire logic        rdr_is_vitc,
	input  wire logic        playing_indication,
	input  wire logic        standby_indication,
	input  wire logic        servo_locked_indication,
	output var  logic        gen_run_q,
	output var  logic        gen_load_q,
	output var  logic [31:0] preset_time_q,
	output var  logic [31:0] preset_user_q,
	output var  logic        ltc_mute_q,
	output var  logic        persist_q,
	output var  logic        nv_write_q
);

	typedef enum logic [1:0] {S_RX, S_EXEC, S_TX} state_t;

	state_t      st_q;
	logic [6:0]  line_q;
	logic [8:0]  tmo_q;
	logic [7:0]  last_err_q;
	logic [7:0]  rxb [FRAME_MAX];
	logic [7:0]  txb [TX_MAX];
	logic [7:0]  rsp [TX_MAX];
	logic [4:0]  widx_q;
	logic [4:0]  need_q;
	logic [7:0]  sum_q;
	logic [7:0]  err_q;
	logic        sum_ok_q;
	logic        ovr_pend_q;
	logic [3:0]  tx_last_q;
	logic [3:0]  tx_idx_q;
	logic        tx_vld_q;
	logic [7:0]  tx_byte_q;
	logic [MS_CNT_W-1:0] ms_cnt_q;
	logic [7:0]  tmo_cnt_q;

	char_link_if lk ();

	serial_char_engine u_eng (
		.clk     (clk),
		.sys_rst (sys_rst),
		.rxd     (rxd),
		.txd_q   (txd_q),
		.lk      (lk.engine)
	);

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	wire logic sel_line = addr == REG_LINE;
	wire logic sel_tmo  = addr == REG_TMO;
	wire logic sel_stat = addr == REG_STAT;
	wire logic [31:0] rd_mux =
		sel_line ? {25'h0, line_q} :
		sel_tmo  ? {23'h0, tmo_q} :
		sel_stat ? {21'h0, ltc_mute_q, persist_q, gen_run_q, last_err_q} :
		32'h0;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			line_q    <= LINE_RST;
			tmo_q     <= TMO_RST;
			rd_data_q <= 32'h0;
		end
		else
		begin
			rd_data_q <= rd_en ? rd_mux : 32'h0;
			if (wr_en && sel_line)
				line_q <= wr_data[LINE_W-1:0];
			else if (wr_en && sel_tmo)
				tmo_q <= wr_data[TMO_W-1:0];
		end
	end

	assign lk.baud_sel = line_q[LINE_BAUD_LSB +: 3];
	assign lk.eight    = line_q[LINE_EIGHT_BIT];
	assign lk.par_mode = line_q[LINE_PAR_LSB +: 2];
	assign lk.two_stop = line_q[LINE_STOP2_BIT];
	assign lk.tx_valid = tx_vld_q;
	assign lk.tx_data  = tx_byte_q;

	// ------------------------------------------------------------
	// Inter-word timeout
	// ------------------------------------------------------------
	// Resolution is one millisecond tick, so the gap ends between
	// ms-1 and ms milliseconds after the last word.
	wire logic ms_tick = ms_cnt_q == MS_CNT_W'(MS_CYCLES - 1);
	wire logic tmo_hit = tmo_q[TMO_EN_BIT] && tmo_q[7:0] != 8'h00
		&& widx_q != 5'd0 && tmo_cnt_q == tmo_q[7:0];

	always_ff @(posedge clk)
	begin
		if (sys_rst || ms_tick)
			ms_cnt_q <= '0;
		else
			ms_cnt_q <= ms_cnt_q + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || lk.rx_valid)
			tmo_cnt_q <= 8'h00;
		else if (ms_tick && tmo_cnt_q != 8'hff)
			tmo_cnt_q <= tmo_cnt_q + 8'h01;
	end

	// ------------------------------------------------------------
	// Frame reception
	// ------------------------------------------------------------
	// A word that meets an expired gap opens a new frame
	wire logic first = widx_q == 5'd0 || tmo_hit;
	wire logic take  = lk.rx_valid && st_q == S_RX && lk.eight;
	wire logic last  = !first && widx_q == need_q - 5'd1;
	wire logic [7:0] rx_flags = (lk.rx_ferr ? ERR_FRAME : 8'h00)
		| (lk.rx_perr ? ERR_PAR : 8'h00);

	always_ff @(posedge clk)
	begin
		if (take)
			rxb[first ? 5'd0 : widx_q] <= lk.rx_data;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			widx_q   <= 5'd0;
			need_q   <= FRAME_OVH;
			sum_q    <= 8'h00;
			err_q    <= 8'h00;
			sum_ok_q <= 1'b0;
		end
		else if (take && first)
		begin
			widx_q <= 5'd1;
			need_q <= {1'b0, lk.rx_data[3:0]} + FRAME_OVH;
			sum_q  <= lk.rx_data;
			err_q  <= rx_flags | (ovr_pend_q ? ERR_OVR : 8'h00);
		end
		else if (take)
		begin
			widx_q   <= last ? 5'd0 : widx_q + 5'd1;
			sum_q    <= sum_q + lk.rx_data;
			err_q    <= err_q | rx_flags;
			sum_ok_q <= sum_q == lk.rx_data;
		end
		else if (tmo_hit)
			widx_q <= 5'd0;
	end

	// Words landing while a return is under way are lost; the
	// next frame reports it as an overrun.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ovr_pend_q <= 1'b0;
		else if (lk.rx_valid && st_q != S_RX)
			ovr_pend_q <= 1'b1;
		else if (take && first)
			ovr_pend_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Command decode and return
	// ------------------------------------------------------------
	wire logic [3:0]  grp = rxb[0][7:4];
	wire logic [3:0]  cnt = rxb[0][3:0];
	wire logic [7:0]  cmd = rxb[1];
	wire logic [7:0]  d1  = rxb[2];
	wire logic [15:0] key = {grp, cnt, cmd};
	wire logic ltc_only  = (d1 & 8'hee) == 8'h00;
	wire logic vitc_only = (d1 & 8'hdd) == 8'h00;
	wire logic want_t    = |d1[3:0];
	wire logic want_u    = |d1[5:4];

	logic        bad_cmd;
	logic        bad_data;
	logic        data_ret;
	logic        is_vitc;
	logic [7:0]  code;
	logic [31:0] src_t;
	logic [31:0] src_u;
	logic [3:0]  rlen;
	logic [7:0]  rsum;
	logic        nak;

	always_comb
	begin
		bad_cmd  = 1'b0;
		bad_data = 1'b0;
		data_ret = 1'b0;
		is_vitc  = 1'b0;
		code     = CODE_GEN_T;
		src_t    = gen_time;
		src_u    = gen_user;
		rsp      = '{default: 8'h00};
		rsp[0]   = ACK_W1;
		rsp[1]   = ACK_W2;
		rlen     = 4'd2;
		case (key)
			{GRP_SYS, 4'd0, CMD_DEVTYPE}:
			begin
				rsp[0] = DEVTYPE_W1;
				rsp[1] = CMD_DEVTYPE;
				rsp[2] = {DEV_TYPE, capability};
				rsp[3] = FW_VERSION;
				rlen   = 4'd4;
			end
			{GRP_SYS, 4'd1, CMD_PERSIST}, {GRP_SYS, 4'd1, CMD_MUTE}:
				bad_data = d1 > 8'h01;
			{GRP_SYS, 4'd1, CMD_GEN}:
				bad_data = d1 > GEN_LOAD;
			{GRP_SET, 4'd4, CMD_PTIME}, {GRP_SET, 4'd4, CMD_PUSER}:
				bad_data = 1'b0;
			{GRP_REQ, 4'd0, CMD_TIMER}:
			begin
				rsp[0] = RET_ONE;
				rsp[1] = CMD_TIMER;
				rlen   = 4'd3;
			end
			{GRP_REQ, 4'd1, CMD_GENREQ}:
			begin
				data_ret = 1'b1;
				code     = want_t ? CODE_GEN_T : CODE_GEN_U;
				bad_data = d1 != SEL_TIME && d1 != SEL_USER && d1 != SEL_BOTH;
			end
			{GRP_REQ, 4'd1, CMD_RDR}:
			begin
				data_ret = 1'b1;
				bad_data = d1[7:6] != 2'b00 || d1[5:0] == 6'h00;
				if (ltc_only)
				begin
					src_t = ltc_time;
					src_u = ltc_user;
					bad_data = bad_data || !capability[CAP_LTC_RD];
				end
				else if (vitc_only)
				begin
					is_vitc = 1'b1;
					src_t = vitc_time;
					src_u = vitc_user;
					bad_data = bad_data || !capability[CAP_VITC_RD];
				end
				else
				begin
					is_vitc = rdr_is_vitc;
					src_t = rdr_time;
					src_u = rdr_user;
				end
				code = is_vitc ? (want_t ? CODE_VITC_T : CODE_VITC_U)
					: (want_t ? CODE_LTC_T : CODE_LTC_U);
			end
			{GRP_REQ, 4'd1, CMD_STAT}:
			begin
				rsp[0] = RET_ONE;
				rsp[1] = CMD_STAT;
				rsp[2] = {5'h00, servo_locked_indication,
					standby_indication, playing_indication};
				rlen   = 4'd3;
			end
			default:
				bad_cmd = 1'b1;
		endcase
		if (data_ret)
		begin
			rsp[0] = (want_t && want_u) ? RET_EIGHT : RET_FOUR;
			rsp[1] = code;
			rlen   = (want_t && want_u) ? 4'd10 : 4'd6;
			for (int i = 0; i < 4; i++)
			begin
				rsp[2 + i] = want_t ? src_t[8*i +: 8] : src_u[8*i +: 8];
				rsp[6 + i] = src_u[8*i +: 8];
			end
		end
		nak = err_q != 8'h00 || !sum_ok_q || bad_cmd || bad_data;
		if (nak)
		begin
			rsp    = '{default: 8'h00};
			rsp[0] = NAK_W1;
			rsp[1] = NAK_W2;
			rsp[2] = err_q | (sum_ok_q ? 8'h00 : ERR_SUM)
				| (bad_data ? ERR_DATA : 8'h00) | (bad_cmd ? ERR_CMD : 8'h00);
			rlen   = 4'd3;
		end
		rsum = 8'h00;
		for (int i = 0; i < TX_MAX - 1; i++)
			if (i < int'(rlen))
				rsum = rsum + rsp[i];
		rsp[rlen] = rsum;
	end

	// ------------------------------------------------------------
	// Sequencer and transmit
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (st_q == S_EXEC)
			txb <= rsp;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_q       <= S_RX;
			tx_vld_q   <= 1'b0;
			tx_byte_q  <= 8'h00;
			tx_idx_q   <= 4'd0;
			tx_last_q  <= 4'd0;
			last_err_q <= 8'h00;
		end
		else
		begin
			tx_vld_q <= 1'b0;
			case (st_q)
				S_RX:
					if (take && last)
						st_q <= S_EXEC;
				S_EXEC:
				begin
					tx_last_q  <= rlen;
					tx_idx_q   <= 4'd0;
					last_err_q <= nak ? rsp[2] : 8'h00;
					st_q       <= S_TX;
				end
				default:
					if (!tx_vld_q && !lk.tx_busy && tx_idx_q > tx_last_q)
						st_q <= S_RX;
					else if (!tx_vld_q && !lk.tx_busy)
					begin
						tx_vld_q  <= 1'b1;
						tx_byte_q <= txb[tx_idx_q];
						tx_idx_q  <= tx_idx_q + 4'd1;
					end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Command effects
	// ------------------------------------------------------------
	wire logic exec_ok = st_q == S_EXEC && !nak;
	wire logic is_gen  = exec_ok && key == {GRP_SYS, 4'd1, CMD_GEN};
	wire logic is_pers = exec_ok && key == {GRP_SYS, 4'd1, CMD_PERSIST};
	wire logic is_mute = exec_ok && key == {GRP_SYS, 4'd1, CMD_MUTE};
	wire logic is_pt   = exec_ok && key == {GRP_SET, 4'd4, CMD_PTIME};
	wire logic is_pu   = exec_ok && key == {GRP_SET, 4'd4, CMD_PUSER};

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			gen_run_q     <= 1'b0;
			gen_load_q    <= 1'b0;
			preset_time_q <= 32'h0;
			preset_user_q <= 32'h0;
			ltc_mute_q    <= 1'b0;
			persist_q     <= PERSIST_RST;
			nv_write_q    <= 1'b0;
		end
		else
		begin
			gen_load_q <= is_gen && d1 == GEN_LOAD;
			nv_write_q <= persist_q && (is_mute || is_pt || is_pu);
			if (is_gen)
				gen_run_q <= d1 != GEN_STOP;
			if (is_pers)
				persist_q <= d1[0];
			if (is_mute)
				ltc_mute_q <= d1[0];
			if (is_pt)
				preset_time_q <= {rxb[5], rxb[4], rxb[3], rxb[2]};
			if (is_pu)
				preset_user_q <= {rxb[5], rxb[4], rxb[3], rxb[2]};
		end
	end

endmodule

`default_nettype wire

// file: tb/tc_ctl_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module tc_ctl_asserts
	import tc_remote_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        txd_q,
	input wire logic [7:0]  addr,
	input wire logic        rd_en,
	input wire logic [31:0] rd_data_q,
	input wire logic        gen_run_q,
	input wire logic        gen_load_q,
	input wire logic        persist_q,
	input wire logic        nv_write_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_load_pulse: assert property (gen_load_q |=> !gen_load_q)
		else $error("load pulse too long");
	chk_load_runs: assert property (gen_load_q |-> ##[0:1] gen_run_q)
		else $error("load did not start generator");
	chk_nv_pulse: assert property (nv_write_q |=> !nv_write_q)
		else $error("store pulse too long");
	chk_nv_persist: assert property (nv_write_q |-> persist_q)
		else $error("store while persistence off");
	chk_reset_idle: assert property ($fell(sys_rst) |-> txd_q && persist_q && !gen_run_q)
		else $error("bad state after reset");
	chk_start_bit: assert property ($fell(txd_q) |-> !txd_q [*8])
		else $error("start bit too short");
	chk_stat_mirror: assert property (rd_en && addr == REG_STAT |=>
		rd_data_q[8] == $past(gen_run_q) && rd_data_q[9] == $past(persist_q))
		else $error("status read mismatch");
	// Commands execute between frames, never while a return is on the line
	chk_run_quiet: assert property ($changed(gen_run_q) |-> txd_q)
		else $error("generator changed during return");
endmodule

bind tc_remote_ctl tc_ctl_asserts chk_u (.clk, .sys_rst, .txd_q, .addr, .rd_en, .rd_data_q,
	.gen_run_q, .gen_load_q, .persist_q, .nv_write_q);

`default_nettype wire

// file: tb/serial_host.sv
`timescale 1ns/10ps
`default_nettype none

module serial_host
	import tc_remote_pkg::*;
(
	input  wire logic clk,
	output var  logic line_q,
	input  wire logic txd
);
	localparam int BIT = DIV_115200;
	logic [7:0] rxq[$];
	logic [7:0] rb;

	// Eight data bits, no parity, one stop; words sent back to back
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_q <= f[i];
			repeat (BIT) @(posedge clk);
		end
	endtask

	initial
	begin
		line_q = 1'b1;
		forever
		begin
			@(negedge txd);
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clk);
				rb[i] = txd;
			end
			repeat (BIT) @(posedge clk);
			rxq.push_back(rb);
		end
	end
endmodule

`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import tc_remote_pkg::*;
	logic        clk, sys_rst, rxd, txd_q, wr_en, rd_en, rdr_is_vitc;
	logic        playing_indication, standby_indication, servo_locked_indication;
	logic        gen_run_q, gen_load_q, ltc_mute_q, persist_q, nv_write_q;
	logic [4:0]  capability;
	logic [7:0]  addr;
	logic [31:0] wr_data, rd_data_q, gen_time, gen_user, ltc_time, ltc_user;
	logic [31:0] vitc_time, vitc_user, rdr_time, rdr_user, preset_time_q, preset_user_q;
	logic [7:0]  q[$];
	int          n_fail, checks;
	int          n_load, n_store;

	// One ms is 50 clocks, so the longest timeout still outlasts one character
	tc_remote_ctl #(.MS_CYCLES(50)) dut_u (.clk, .sys_rst, .rxd, .txd_q, .addr, .wr_data, .wr_en,
		.rd_en, .rd_data_q, .capability, .gen_time, .gen_user, .ltc_time, .ltc_user, .vitc_time,
		.vitc_user, .rdr_time, .rdr_user, .rdr_is_vitc, .playing_indication, .standby_indication,
		.servo_locked_indication, .gen_run_q, .gen_load_q, .preset_time_q, .preset_user_q,
		.ltc_mute_q, .persist_q, .nv_write_q);
	serial_host host_u (.clk, .line_q(rxd), .txd(txd_q));

	// One-cycle strobes are counted so the end checks cannot miss them
	always @(posedge clk)
	begin
		n_load  <= n_load + int'(gen_load_q === 1'b1);
		n_store <= n_store + int'(nv_write_q === 1'b1);
	end

	function automatic logic [7:0] csum(input logic [7:0] w[$]);
		csum = 8'h00;
		foreach (w[i])
			csum += w[i];
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk("rd_data", e, rd_data_q);
		@(posedge clk);
	endtask

	task automatic give_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		void'($urandom(68140));
		{sys_rst, wr_en, rd_en, addr, wr_data} <= {1'b1, 42'h0};
		{gen_time, gen_user, ltc_time, ltc_user} <= {$urandom, $urandom, $urandom, $urandom};
		{vitc_time, vitc_user, rdr_time, rdr_user} <= {$urandom, $urandom, $urandom, $urandom};
		{rdr_is_vitc, playing_indication, standby_indication, servo_locked_indication, capability} <= 9'($urandom);
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(REG_LINE, 32'h0c);
		rd(REG_TMO, 32'h10a);
		rd(8'h40, 32'h0);
		wr(REG_LINE, 32'h0e);
		wr(REG_TMO, 32'h1ff);
		rd(REG_TMO, 32'h1ff);
		// Any single word is a partial frame, since a frame holds at least three
		host_u.send(8'($urandom));
		repeat (13000) @(posedge clk);
		q = '{8'h01, CMD_GEN, GEN_LOAD};
		q.push_back(csum(q));
		foreach (q[i])
			host_u.send(q[i]);
		for (int i = 0; i < 40000 && host_u.rxq.size() < 3; i++)
			@(posedge clk);
		chk("ret_count", 32'd3, 32'(host_u.rxq.size()));
		if (host_u.rxq.size() >= 3)
		begin
			q = '{ACK_W1, ACK_W2};
			q.push_back(csum(q));
			foreach (q[i])
				chk("ret_word", 32'(q[i]), 32'(host_u.rxq[i]));
		end
		chk("gen_run", 32'h1, 32'(gen_run_q));
		chk("gen_load", 32'd1, 32'(n_load));
		chk("nv_write", 32'd0, 32'(n_store));
		chk("preset_time", 32'h0, preset_time_q);
		chk("preset_user", 32'h0, preset_user_q);
		rd(REG_STAT, 32'h300);
		give_verdict();
	end
endmodule

`default_nettype wire
